// [hdl/arb_params.svh]
// Purpose: Offsets, field positions and reset values of the interrupt arbiter
// Assumes: APB byte address = word index * 4
// Notes: Definitions only
`ifndef ARB_PARAMS_SVH
`define ARB_PARAMS_SVH

// Word indices (paddr[7:2])
`define IDX_PRIO0 6'h00
`define IDX_PRIO_LAST 6'h05
`define IDX_ENABLE0 6'h06
`define IDX_ENABLE_LAST 6'h08
`define IDX_VECTOR_BASE 6'h09
`define IDX_FAST_MATCH_ZERO 6'h0A
`define IDX_FAST_LOW_ZERO 6'h0B
`define IDX_FAST_HIGH_ZERO 6'h0C
`define IDX_FAST_MATCH_ONE 6'h0D
`define IDX_FAST_LOW_ONE 6'h0E
`define IDX_FAST_HIGH_ONE 6'h0F
`define IDX_PENDING0 6'h10
`define IDX_PENDING_LAST 6'h12
`define IDX_CONTROL 6'h13
`define IDX_EVT_STATUS 6'h14
`define IDX_EVT_MASK 6'h15
`define IDX_ARB_STATE 6'h16

// Reset values and fixed levels
`define RST_VECTOR_BASE 14'h0000
`define RST_BOOT_ADDR 21'h000000
`define RST_FAST_MATCH 7'h00
`define RST_FAST_HALF 16'h0000
`define FIXED_LEVEL 2'h3
`define FAST_LEVEL 2'h2

// Field positions
`define CTRL_EDGE_A_BIT 0
`define CTRL_EDGE_B_BIT 1
`define EVT_ACK_BIT 0
`define EVT_WAKE_BIT 1
`define EVT_W 2

`endif

// [hdl/arb_pkg.sv]
// Purpose: Types shared by the interrupt arbiter
// Assumes: Nothing
// Notes: Gray-coded sequencer states
package arb_pkg;
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_IDLE = 2'b01,
        ST_REQ = 2'b11
    } arb_state_e;
    typedef logic [1:0] level_t;
endpackage : arb_pkg

// [hdl/interrupt_arbiter.sv]
// Purpose: Four-level vectored interrupt arbiter with fast slots, wake and APB slave
// Assumes: req_in, core and low-power inputs are synchronous to sys_clk
// Notes: APB answers with one wait state
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "arb_params.svh"

module interrupt_arbiter
    import arb_pkg::*;
#(
    parameter int NUM_SRC = 82,
    parameter int NUM_FIXED = 2,
    parameter int EXT_A_SRC = 2,
    parameter int EXT_B_SRC = 3,
    parameter int VEC_W = 7,
    parameter int VB_W = 14,
    parameter int ADDR_OUT_W = 21
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request sources and external pins
    input wire logic [NUM_SRC-1:0] req_in,
    input wire logic external_request_a_b,
    input wire logic external_request_b_b,
    // Processor core
    input wire logic [1:0] core_status_mask,
    input wire logic [1:0] current_level_code,
    input wire logic core_ack,
    output logic core_irq,
    output logic [ADDR_OUT_W-1:0] core_vector_addr,
    output logic [1:0] core_irq_level,
    output logic core_fast,
    output logic boot_addr_valid,
    // System integration unit
    input wire logic low_power,
    output logic wake_request,
    // Event interrupt
    output logic irq_out
);
    localparam int FH_W = ADDR_OUT_W - 16;

    ////////////////////////////////////////////////////////////////////////////
    // State
    level_t prio_reg [NUM_SRC];
    level_t prio_next [NUM_SRC];
    logic [NUM_SRC-1:0] enable_reg, enable_next, wake_en_reg, wake_en_next;
    logic [VB_W-1:0] vbase_reg, vbase_next;
    logic [VEC_W-1:0] fm0_reg, fm0_next, fm1_reg, fm1_next, vec_reg, vec_next;
    logic [15:0] fl0_reg, fl0_next, fl1_reg, fl1_next;
    logic [FH_W-1:0] fh0_reg, fh0_next, fh1_reg, fh1_next;
    logic [1:0] ctrl_reg, ctrl_next, edge_pend_reg, edge_pend_next;
    logic [`EVT_W-1:0] status_reg, status_next, mask_reg, mask_next;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next, irq_out_next, wake_next;
    logic ext_a_s1, ext_a_s2, ext_a_s3, ext_b_s1, ext_b_s2, ext_b_s3;
    arb_state_e state_reg, state_next;
    logic core_irq_next, core_fast_next, boot_next;
    logic [ADDR_OUT_W-1:0] addr_next;
    level_t level_next;

    ////////////////////////////////////////////////////////////////////////////
    // External pins: two-flop synchroniser, third flop for edges
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {ext_a_s1, ext_a_s2, ext_a_s3} <= 3'h7;
            {ext_b_s1, ext_b_s2, ext_b_s3} <= 3'h7;
        end else begin
            {ext_a_s1, ext_a_s2, ext_a_s3} <= {external_request_a_b, ext_a_s1, ext_a_s2};
            {ext_b_s1, ext_b_s2, ext_b_s3} <= {external_request_b_b, ext_b_s1, ext_b_s2};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration
    logic [NUM_SRC-1:0] src_level, active, lower_same;
    logic [3:0] level_hit;
    level_t thr, win_level;
    logic win_found, fast_hit0, fast_hit1, ack_take;
    logic [VEC_W-1:0] win_vec;

    always_comb begin
        src_level = req_in;
        // Clock is gone in low power, so edge mode falls back to low level
        src_level[EXT_A_SRC] = (ctrl_reg[`CTRL_EDGE_A_BIT] && !low_power) ?
                               edge_pend_reg[0] : !ext_a_s2;
        src_level[EXT_B_SRC] = (ctrl_reg[`CTRL_EDGE_B_BIT] && !low_power) ?
                               edge_pend_reg[1] : !ext_b_s2;
        active = src_level & enable_reg;
        // Threshold is the stricter of core mask and nesting level
        thr = (core_status_mask > current_level_code) ? core_status_mask
                                                      : current_level_code;
        level_hit = 4'h0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (active[s]) begin
                level_hit[prio_reg[s]] = 1'b1;
            end
        end
        win_found = 1'b0;
        win_level = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (level_hit[l] && l >= thr) begin
                win_found = 1'b1;
                win_level = level_t'(l);
            end
        end
        win_vec = '0;
        for (int s = NUM_SRC - 1; s >= 0; s--) begin
            if (active[s] && prio_reg[s] == win_level) begin
                win_vec = VEC_W'(s);
            end
        end
        fast_hit0 = (win_level == `FAST_LEVEL) && (win_vec == fm0_reg);
        fast_hit1 = (win_level == `FAST_LEVEL) && (win_vec == fm1_reg) && !fast_hit0;
        ack_take = (state_reg == ST_REQ) && core_ack;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core sequencer
    always_comb begin
        state_next = state_reg;
        core_irq_next = core_irq;
        core_fast_next = core_fast;
        addr_next = core_vector_addr;
        level_next = core_irq_level;
        vec_next = vec_reg;
        boot_next = 1'b0;
        case (state_reg)
            ST_BOOT: begin
                state_next = ST_IDLE;
            end
            ST_IDLE: begin
                if (win_found) begin
                    core_irq_next = 1'b1;
                    level_next = win_level;
                    vec_next = win_vec;
                    core_fast_next = fast_hit0 || fast_hit1;
                    if (fast_hit0) begin
                        addr_next = {fh0_reg, fl0_reg};
                    end else if (fast_hit1) begin
                        addr_next = {fh1_reg, fl1_reg};
                    end else begin
                        addr_next = {vbase_reg, win_vec};
                    end
                    state_next = ST_REQ;
                end
            end
            ST_REQ: begin
                // Held until acknowledged; a later winner waits its turn
                if (core_ack) begin
                    core_irq_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                core_irq_next = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file, edge latches, wake and events
    logic [5:0] idx;
    logic hit, wr, rd;

    always_comb begin
        idx = paddr[7:2];
        hit = (paddr[1:0] == 2'h0) && (idx <= `IDX_ARB_STATE);
        wr = psel && penable && pready && pwrite && hit;
        rd = psel && penable && !pready;
        for (int s = 0; s < NUM_SRC; s++) begin
            prio_next[s] = prio_reg[s];
            if (wr && idx == 6'(s / 16) && s >= NUM_FIXED) begin
                prio_next[s] = pwdata[2 * (s % 16) +: 2];
            end
        end
        enable_next = enable_reg;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (wr && idx == 6'(`IDX_ENABLE0 + s / 32)) begin
                enable_next[s] = pwdata[s % 32];
            end
        end
        vbase_next = (wr && idx == `IDX_VECTOR_BASE) ? pwdata[VB_W-1:0] : vbase_reg;
        fm0_next = (wr && idx == `IDX_FAST_MATCH_ZERO) ? pwdata[VEC_W-1:0] : fm0_reg;
        fl0_next = (wr && idx == `IDX_FAST_LOW_ZERO) ? pwdata[15:0] : fl0_reg;
        fh0_next = (wr && idx == `IDX_FAST_HIGH_ZERO) ? pwdata[FH_W-1:0] : fh0_reg;
        fm1_next = (wr && idx == `IDX_FAST_MATCH_ONE) ? pwdata[VEC_W-1:0] : fm1_reg;
        fl1_next = (wr && idx == `IDX_FAST_LOW_ONE) ? pwdata[15:0] : fl1_reg;
        fh1_next = (wr && idx == `IDX_FAST_HIGH_ONE) ? pwdata[FH_W-1:0] : fh1_reg;
        ctrl_next = (wr && idx == `IDX_CONTROL) ? pwdata[1:0] : ctrl_reg;
        mask_next = (wr && idx == `IDX_EVT_MASK) ? pwdata[`EVT_W-1:0] : mask_reg;
        // Falling edge sets; acknowledge of that source clears; set wins
        edge_pend_next[0] = (ext_a_s3 && !ext_a_s2) ||
                            (edge_pend_reg[0] && !(ack_take && vec_reg == VEC_W'(EXT_A_SRC)));
        edge_pend_next[1] = (ext_b_s3 && !ext_b_s2) ||
                            (edge_pend_reg[1] && !(ack_take && vec_reg == VEC_W'(EXT_B_SRC)));
        // Wake enables are frozen while the clocks are off
        wake_en_next = low_power ? wake_en_reg : enable_reg;
        wake_next = low_power && |(src_level & wake_en_reg);
        status_next = status_reg & ~((wr && idx == `IDX_EVT_STATUS) ? pwdata[`EVT_W-1:0]
                                                                     : `EVT_W'(0));
        status_next[`EVT_ACK_BIT] = status_next[`EVT_ACK_BIT] || ack_take;
        status_next[`EVT_WAKE_BIT] = status_next[`EVT_WAKE_BIT] || (wake_next && !wake_request);
        irq_out_next = |(status_reg & mask_reg);
        pready_next = rd;
        pslverr_next = rd && !hit;
        prdata_next = prdata;
        if (rd) begin
            prdata_next = 32'h0;
            if (idx <= `IDX_PRIO_LAST) begin
                for (int s = 0; s < NUM_SRC; s++) begin
                    if (idx == 6'(s / 16)) begin
                        prdata_next[2 * (s % 16) +: 2] = prio_reg[s];
                    end
                end
            end
            for (int s = 0; s < NUM_SRC; s++) begin
                if (idx == 6'(`IDX_ENABLE0 + s / 32)) begin
                    prdata_next[s % 32] = enable_reg[s];
                end
                if (idx == 6'(`IDX_PENDING0 + s / 32)) begin
                    prdata_next[s % 32] = active[s];
                end
            end
            case (idx)
                `IDX_VECTOR_BASE: prdata_next[VB_W-1:0] = vbase_reg;
                `IDX_FAST_MATCH_ZERO: prdata_next[VEC_W-1:0] = fm0_reg;
                `IDX_FAST_LOW_ZERO: prdata_next[15:0] = fl0_reg;
                `IDX_FAST_HIGH_ZERO: prdata_next[FH_W-1:0] = fh0_reg;
                `IDX_FAST_MATCH_ONE: prdata_next[VEC_W-1:0] = fm1_reg;
                `IDX_FAST_LOW_ONE: prdata_next[15:0] = fl1_reg;
                `IDX_FAST_HIGH_ONE: prdata_next[FH_W-1:0] = fh1_reg;
                `IDX_CONTROL: prdata_next[1:0] = ctrl_reg;
                `IDX_EVT_STATUS: prdata_next[`EVT_W-1:0] = status_reg;
                `IDX_EVT_MASK: prdata_next[`EVT_W-1:0] = mask_reg;
                `IDX_ARB_STATE: prdata_next[13:0] = {core_irq, core_fast, state_reg,
                                                    core_irq_level, 1'b0, vec_reg};
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int s = 0; s < NUM_SRC; s++) begin
                prio_reg[s] <= (s < NUM_FIXED) ? `FIXED_LEVEL : 2'h0;
            end
            enable_reg <= '0;
            wake_en_reg <= '0;
            vbase_reg <= `RST_VECTOR_BASE;
            fm0_reg <= `RST_FAST_MATCH;
            fm1_reg <= `RST_FAST_MATCH;
            fl0_reg <= `RST_FAST_HALF;
            fl1_reg <= `RST_FAST_HALF;
            fh0_reg <= '0;
            fh1_reg <= '0;
            ctrl_reg <= 2'h0;
            edge_pend_reg <= 2'h0;
            status_reg <= '0;
            mask_reg <= '0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq_out <= 1'b0;
            wake_request <= 1'b0;
            state_reg <= ST_BOOT;
            core_irq <= 1'b0;
            core_fast <= 1'b0;
            core_vector_addr <= `RST_BOOT_ADDR;
            core_irq_level <= 2'h0;
            vec_reg <= '0;
            boot_addr_valid <= 1'b1;
        end else begin
            prio_reg <= prio_next;
            enable_reg <= enable_next;
            wake_en_reg <= wake_en_next;
            vbase_reg <= vbase_next;
            fm0_reg <= fm0_next;
            fm1_reg <= fm1_next;
            fl0_reg <= fl0_next;
            fl1_reg <= fl1_next;
            fh0_reg <= fh0_next;
            fh1_reg <= fh1_next;
            ctrl_reg <= ctrl_next;
            edge_pend_reg <= edge_pend_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            irq_out <= irq_out_next;
            wake_request <= wake_next;
            state_reg <= state_next;
            core_irq <= core_irq_next;
            core_fast <= core_fast_next;
            core_vector_addr <= addr_next;
            core_irq_level <= level_next;
            vec_reg <= vec_next;
            boot_addr_valid <= boot_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    always_comb begin
        lower_same = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            lower_same[s] = active[s] && prio_reg[s] == win_level && VEC_W'(s) < win_vec;
        end
    end

    a_lowest_in_level: assert property (win_found |-> lower_same == '0)
        else $error("lower source in winning level was passed over");
    a_top_level_pick: assert property (win_found |-> (level_hit >> (win_level + 1)) == 4'h0)
        else $error("a higher level with a request was passed over");
    a_mask_kept: assert property ($rose(core_irq) |-> core_irq_level >= $past(core_status_mask))
        else $error("masked level reached the core");
    a_nest_kept: assert property ($rose(core_irq) |-> core_irq_level >= $past(current_level_code))
        else $error("level not allowed to nest reached the core");
    a_normal_vector: assert property (state_reg == ST_IDLE && win_found && !fast_hit0 && !fast_hit1
        |=> core_irq && core_vector_addr == {$past(vbase_reg), $past(win_vec)})
        else $error("normal vector address wrong");
    a_fast_vector: assert property (state_reg == ST_IDLE && win_found && fast_hit0
        |=> core_fast && core_vector_addr == {$past(fh0_reg), $past(fl0_reg)})
        else $error("fast slot address not used");
    a_hold_until_ack: assert property (core_irq && !core_ack
        |=> core_irq && $stable(core_vector_addr) && $stable(core_irq_level))
        else $error("request changed before acknowledge");
    a_wake_raise: assert property (low_power && |(src_level & wake_en_reg) |=> wake_request)
        else $error("wake not signalled");
    a_ext_level_low: assert property (low_power && !ext_a_s2 |-> src_level[EXT_A_SRC])
        else $error("external request not level sensitive in low power");
    a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one wait state");
    a_boot_release: assert property (state_reg == ST_BOOT && rst_b |-> boot_addr_valid
        && core_vector_addr == `RST_BOOT_ADDR ##1 state_reg == ST_IDLE)
        else $error("boot address not driven");

    c_fast_taken: cover property (core_fast && core_ack);
    c_nested_grant: cover property ($rose(core_irq) && current_level_code != 2'h0);
    c_wake_seen: cover property ($rose(wake_request));
    c_apb_error: cover property (pslverr && pready);

endmodule : interrupt_arbiter

// [testbench/core_side_model.sv]
// Purpose: Processor-core stand-in facing the arbiter
// Assumes: One clock, reset asynchronous and active low
// Notes: Acknowledge latency set by the bench, prompt or slow
`timescale 1ns/1ns
module core_side_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // From the arbiter
    input wire logic core_irq,
    input wire logic [20:0] core_vector_addr,
    input wire logic [1:0] core_irq_level,
    input wire logic core_fast,
    // Bench controls
    input wire logic [3:0] ack_delay,
    input wire logic [1:0] want_mask,
    input wire logic [1:0] want_code,
    // To the arbiter
    output logic core_ack,
    output logic [1:0] core_status_mask,
    output logic [1:0] current_level_code,
    // Observations
    output logic [23:0] taken,
    output logic [15:0] n_taken,
    output logic moved
);
    logic [3:0] wait_cnt;
    logic held;
    logic [23:0] last_seen;
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_ack <= 1'b0;
            core_status_mask <= 2'h0;
            current_level_code <= 2'h0;
            taken <= 24'h0;
            n_taken <= 16'h0;
            moved <= 1'b0;
            wait_cnt <= 4'h0;
            held <= 1'b0;
            last_seen <= 24'h0;
        end else begin
            core_status_mask <= want_mask;
            current_level_code <= want_code;
            core_ack <= 1'b0;
            wait_cnt <= 4'h0;
            // One-cycle acknowledge, only while a request is up
            if (core_irq && !core_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
                core_ack <= (wait_cnt == ack_delay);
            end
            if (core_ack) begin
                taken <= {core_fast, core_irq_level, core_vector_addr};
                n_taken <= n_taken + 16'h1;
            end
            held <= core_irq && !core_ack;
            last_seen <= {core_fast, core_irq_level, core_vector_addr};
            if (held && core_irq && {core_fast, core_irq_level, core_vector_addr} !== last_seen)
                moved <= 1'b1;
        end
    end
endmodule : core_side_model

// [testbench/interrupt_arbiter_tb_top.sv]
// Purpose: Self-checking bench for the interrupt arbiter
// Assumes: Default parameters, one 50 MHz clock
// Notes: Levels, requests and masks random from a fixed seed
`timescale 1ns/1ns
`include "arb_params.svh"
module interrupt_arbiter_tb_top;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err, core_ack, core_irq;
    logic core_fast, boot_addr_valid, low_power, wake_request, irq_out, moved;
    logic external_request_a_b, external_request_b_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, wd, ex;
    logic [81:0] req_in, r;
    logic [1:0] core_status_mask, current_level_code, want_mask, want_code, core_irq_level;
    logic [20:0] core_vector_addr;
    logic [3:0] ack_delay;
    logic [23:0] taken;
    logic [15:0] n_taken;
    logic [1:0] lvl [82];
    logic [13:0] vb;
    logic [15:0] fl [2];
    logic [4:0] fh [2];
    logic [6:0] fm [2];
    int n_mismatch, checked, win, wins;

    interrupt_arbiter interrupt_arbiter_i (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .req_in, .external_request_a_b,
        .external_request_b_b, .core_status_mask, .current_level_code, .core_ack, .core_irq,
        .core_vector_addr, .core_irq_level, .core_fast, .boot_addr_valid, .low_power,
        .wake_request, .irq_out);
    core_side_model core_side_model_i (.sys_clk, .rst_b, .core_irq, .core_vector_addr,
        .core_irq_level, .core_fast, .ack_delay, .want_mask, .want_code, .core_ack,
        .core_status_mask, .current_level_code, .taken, .n_taken, .moved);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic flag(input int sel);
        if (sel == 0) return core_ack === 1'b1;
        if (sel == 1) return wake_request === 1'b1;
        return irq_out === 1'b1;
    endfunction : flag

    // Bounded wait; running out ends the run as a mismatch
    task automatic wait_on(input int sel);
        int i;
        for (i = 0; i < 40 && !flag(sel); i++) @(posedge sys_clk);
        if (i == 40) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_on

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wdat);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wdat;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 8 && pready !== 1'b1; i++) @(posedge sys_clk);
        if (i == 8) begin
            n_mismatch++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Highest permitted level first, then lowest source number there
    function automatic int pick(input logic [81:0] q, input logic [1:0] thr);
        for (int l = 3; l >= 0; l--)
            for (int s = 0; s < 82; s++)
                if (q[s] && lvl[s] == l && l >= thr) return s;
        return -1;
    endfunction : pick

    function automatic logic [23:0] expect_taken(input int s);
        for (int k = 0; k < 2; k++)
            if (lvl[s] == `FAST_LEVEL && fm[k] == s[6:0]) return {1'b1, lvl[s], fh[k], fl[k]};
        return {1'b0, lvl[s], vb, s[6:0]};
    endfunction : expect_taken
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        req_in = '0;
        external_request_a_b = 1'b1;
        external_request_b_b = 1'b1;
        low_power = 1'b0;
        want_mask = 2'h0;
        want_code = 2'h0;
        ack_delay = 4'h0;
        void'($urandom(32'hB108));
        repeat (8) @(posedge sys_clk);
        chk("boot_valid", 32'h1, 32'(boot_addr_valid));
        chk("boot_addr", 32'(`RST_BOOT_ADDR), 32'(core_vector_addr));
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("boot_done", 32'h0, 32'(boot_addr_valid));
        vb = 14'($urandom);
        for (int k = 0; k < 2; k++) begin
            fm[k] = k ? 7'h2D : 7'h14;
            fl[k] = 16'($urandom);
            fh[k] = 5'($urandom);
            apb(1'b1, 6'(`IDX_FAST_MATCH_ZERO + 3 * k), 32'(fm[k]));
            apb(1'b1, 6'(`IDX_FAST_LOW_ZERO + 3 * k), 32'(fl[k]));
            apb(1'b1, 6'(`IDX_FAST_HIGH_ZERO + 3 * k), 32'(fh[k]));
        end
        for (int s = 0; s < 82; s++) lvl[s] = (s < 2) ? `FIXED_LEVEL : 2'($urandom);
        lvl[20] = `FAST_LEVEL;
        lvl[45] = `FAST_LEVEL;
        for (int w = 0; w < 6; w++) begin
            for (int j = 0; j < 16; j++) begin
                wd[2*j+:2] = (16 * w + j < 2 || 16 * w + j > 81) ? 2'h0 : lvl[16*w+j];
                ex[2*j+:2] = (16 * w + j > 81) ? 2'h0 : lvl[16*w+j];
            end
            apb(1'b1, 6'(`IDX_PRIO0 + w), wd);
            apb(1'b0, 6'(`IDX_PRIO0 + w), 32'h0);
            chk("prio", w == 5 ? ex & 32'hF : ex, w == 5 ? rd & 32'hF : rd);
        end
        for (int w = 0; w < 3; w++) apb(1'b1, 6'(`IDX_ENABLE0 + w), 32'hFFFFFFFF);
        apb(1'b1, `IDX_VECTOR_BASE, 32'(vb));
        apb(1'b0, `IDX_VECTOR_BASE, 32'h0);
        chk("vector_base", 32'(vb), rd);
        apb(1'b0, 6'h17, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        // Corners first: all requests, then each fast slot alone
        for (int t = 0; t < 40; t++) begin
            want_mask <= t < 3 ? 2'h0 : 2'($urandom);
            want_code <= t < 3 ? 2'h0 : 2'($urandom);
            ack_delay <= 4'($urandom % 6);
            repeat (3) @(posedge sys_clk);
            r = 82'({$urandom, $urandom, $urandom} & {$urandom, $urandom, $urandom});
            r = t == 0 ? '1 : t == 1 ? 82'h1 << 20 : t == 2 ? 82'h1 << 45 : r;
            r[3:2] = 2'h0;
            win = pick(r, want_mask > want_code ? want_mask : want_code);
            req_in <= r;
            if (win < 0) begin
                repeat (6) @(posedge sys_clk);
                chk("blocked_irq", 32'h0, 32'(core_irq));
            end else begin
                wait_on(0);
                req_in <= '0;
                wins++;
                repeat (3) @(posedge sys_clk);
                chk("vector", 32'(expect_taken(win)), 32'(taken));
            end
            req_in <= '0;
            repeat (3) @(posedge sys_clk);
        end
        chk("taken_count", 32'(wins), 32'(n_taken));
        chk("stable_vector", 32'h0, 32'(moved));
        apb(1'b0, `IDX_EVT_STATUS, 32'h0);
        chk("evt_status", 32'h1, rd);
        chk("irq_masked", 32'h0, 32'(irq_out));
        apb(1'b1, `IDX_EVT_MASK, 32'h3);
        wait_on(2);
        apb(1'b1, `IDX_EVT_STATUS, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq_cleared", 32'h0, 32'(irq_out));
        // Only the pin source is enabled before entering low power
        apb(1'b1, `IDX_ENABLE0, 32'h4);
        apb(1'b1, 6'(`IDX_ENABLE0 + 1), 32'h0);
        apb(1'b1, 6'(`IDX_ENABLE0 + 2), 32'h0);
        apb(1'b1, `IDX_CONTROL, 32'h1);
        low_power <= 1'b1;
        apb(1'b1, `IDX_ENABLE0, 32'h404);
        req_in[10] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("late_enable_wake", 32'h0, 32'(wake_request));
        external_request_a_b <= 1'b0;
        wait_on(1);
        apb(1'b0, `IDX_EVT_STATUS, 32'h0);
        chk("wake_event", 32'h2, rd & 32'h2);
        // Pin B in edge mode outside low power: a short pulse is served exactly once
        low_power <= 1'b0;
        want_mask <= 2'h0;
        want_code <= 2'h0;
        req_in <= '0;
        apb(1'b1, `IDX_ENABLE0, 32'h8);
        apb(1'b1, `IDX_CONTROL, 32'h2);
        repeat (10) @(posedge sys_clk);
        wins = n_taken;
        external_request_b_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        external_request_b_b <= 1'b1;
        wait_on(0);
        repeat (8) @(posedge sys_clk);
        chk("edge_vector", 32'(expect_taken(3)), 32'(taken));
        chk("edge_once", 32'(wins + 1), 32'(n_taken));
        print_verdict();
    end
endmodule : interrupt_arbiter_tb_top
